// file: verilog/rtchs_host_seq.sv
// Host sequencer that brings up, sets, reads and services the clock chip.
// What this block does
// (R01) Wait for supply detect high and settling time.
// (R02) Read cold start flag; zero means backup resume.
// (R03) Clear supply drop flag after each seconds write.
// (R04) Write seconds through year in one frame.
// (R05) Read seconds through year in one frame.
// (R06) Program the periodic interrupt in level mode.
// (R07) Write zero to periodic flag to cancel.
// (R08) Reduced reads allowed for plain time display.
// (R09) Full read only first session after time write.
// (R10) Clear alarm enable before loading alarm time.
// (R11) Set alarm enable after all alarm registers.
// (R12) Cancel alarms with never-matching register patterns.
// (R13) Device holds interrupt low until flag cleared.
// (R14) Alarm enable bits gate alarm interrupts independently.
// (R15) Device keeps counters coherent during a frame.
// (R16) After cold start, write adjustment and interrupt setup.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rtchs_host_seq #(
	parameter int POWER_INIT_CYCLES = rtchs_pkg::POWER_INIT_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Software register port.
	input  wire logic [4:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic [7:0]      regRdata,
	output logic            irq,
	// Three-wire link to the clock chip.
	output logic            ceOut,
	output logic            sclkOut,
	output logic            serialDataLineOut,
	output logic            serialDataLineOe,
	input  wire logic       serialDataLineIn,
	// Open-drain status pins of the clock chip.
	input  wire logic       supplyDetectOut,
	input  wire logic       irqOutN
);
	import rtchs_pkg::*;

	logic         supMeta;
	logic         supSync;
	logic         irqMeta;
	logic         irqSync;
	logic [27:0]  pwrCnt;
	logic         powerReady;
	logic [2:0]   cfg;
	logic [2:0]   periodSel;
	logic [7:0]   oscAdj;
	logic [7:0]   timeBuf [7];
	logic [7:0]   alarmW [3];
	logic [7:0]   alarmD [2];
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic [EV_W-1:0] evSet;
	rtchs_state_e state;
	rtchs_op_e    op;
	rtchs_op_e    cmdOp;
	logic [1:0]   step;
	logic [2:0]   byteIdx;
	logic [7:0]   gapCnt;
	logic         servicing;
	logic         coldStart;
	logic         needFull;
	logic         wEn;
	logic         dEn;
	logic         shStart;
	logic [7:0]   shByte;
	logic         shWrite;
	logic         shDone;
	logic [7:0]   shRx;
	logic         pValid;
	logic [3:0]   pAddr;
	logic [2:0]   pLen;
	logic         pWrite;
	logic [7:0]   pByte;
	logic         cmdWr;
	logic         frameEnd;
	logic         opEnd;
	logic [7:0]   next_rdata;

	rtchs_serial_shifter shifter (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.start   (shStart),
		.txByte  (shByte),
		.isWrite (shWrite),
		.done    (shDone),
		.rxByte  (shRx),
		.sclkOut (sclkOut),
		.sdOut   (serialDataLineOut),
		.sdOe    (serialDataLineOe),
		.sdIn    (serialDataLineIn)
	);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			supMeta <= 1'b0;
			supSync <= 1'b0;
			irqMeta <= 1'b1;
			irqSync <= 1'b1;
		end else begin
			supMeta <= supplyDetectOut;
			supSync <= supMeta;
			irqMeta <= irqOutN;
			irqSync <= irqMeta;
		end
	end

	// The settling time restarts whenever the supply detect pin drops.
	always_ff @(posedge ref_clk) begin
		if (!rstn || !supSync) begin
			pwrCnt <= 28'h0000000; // R01
		end else if (!powerReady) begin
			pwrCnt <= pwrCnt + 28'h0000001;
		end
	end
	assign powerReady = (pwrCnt == 28'(POWER_INIT_CYCLES)); // R01

	function automatic logic [7:0] ctrl1Word(input logic w, input logic d,
		input logic [2:0] sel);
		logic [7:0] v;
		v = 8'h00;
		v[CT1_WEEKDAY_EN_BIT] = w;
		v[CT1_DAILY_EN_BIT]   = d;
		// Any enabled periodic cycle is forced into level mode.
		v[2:0] = (sel == 3'h0) ? 3'h0 : (sel | CT1_LEVEL_MODE); // R06
		return v;
	endfunction

	always_comb begin
		unique case (regWdata)
			CMD_INIT:      cmdOp = OP_INIT;
			CMD_SET_TIME:  cmdOp = OP_SET_TIME;
			CMD_READ_TIME: cmdOp = OP_READ_TIME;
			CMD_ALARM_W:   cmdOp = OP_ALARM_W;
			CMD_ALARM_D:   cmdOp = OP_ALARM_D;
			CMD_CANCEL:    cmdOp = OP_CANCEL;
			default:       cmdOp = OP_NONE;
		endcase
	end

	// Frame plan for the current operation step and byte.
	always_comb begin
		pValid = 1'b0;
		pAddr  = DEV_SEC;
		pLen   = 3'h1;
		pWrite = 1'b1;
		pByte  = 8'h00;
		unique case (op)
			OP_INIT: begin
				unique case (step)
					2'h0: begin
						pValid = 1'b1;
						pAddr  = DEV_CTRL1;
						pWrite = 1'b0; // R02
					end
					2'h1: begin
						pValid = coldStart; // R16
						pAddr  = DEV_OSC_ADJ;
						pByte  = oscAdj;
					end
					2'h2: begin
						pValid = coldStart; // R16
						pAddr  = DEV_CTRL1;
						pByte  = ctrl1Word(wEn, dEn, periodSel);
					end
					default: ;
				endcase
			end
			OP_SET_TIME: begin
				if (step == 2'h0) begin
					pValid = 1'b1;
					pLen   = TIME_BYTES; // R04
					pByte  = timeBuf[byteIdx];
				end else if (step == 2'h1) begin
					pValid = cfg[CFG_MONITOR]; // R03
					pAddr  = DEV_CTRL2;
					pByte  = CT2_KEEP;
					pByte[CT2_DROP_BIT] = 1'b0; // R03
				end
			end
			OP_READ_TIME: begin
				if (step == 2'h0) begin
					pValid = 1'b1;
					pWrite = 1'b0;
					pLen   = (cfg[CFG_REDUCED] && !needFull) ?
						REDUCED_BYTES : TIME_BYTES; // R05 R08 R09
				end else if (step == 2'h1) begin
					pValid = servicing;
					pAddr  = DEV_CTRL2;
					pByte  = CT2_KEEP;
					pByte[CT2_PERIODIC_BIT] = 1'b0; // R07
				end
			end
			OP_ALARM_W, OP_ALARM_D, OP_CANCEL: begin
				pValid = (step != 2'h3);
				pAddr  = DEV_CTRL1;
				if (step == 2'h0) begin
					pByte = (op == OP_ALARM_D) ?
						ctrl1Word(wEn, 1'b0, periodSel) :
						ctrl1Word(1'b0, dEn & (op == OP_ALARM_W),
							periodSel); // R10 R12
				end else if (step == 2'h1) begin
					pAddr = (op == OP_ALARM_D) ? DEV_ALARM_D : DEV_ALARM_W;
					pLen  = (op == OP_ALARM_D) ? ALARM_D_BYTES :
						ALARM_W_BYTES;
					pByte = (op == OP_CANCEL) ? ALARM_W_CANCEL :
						(op == OP_ALARM_D) ? alarmD[byteIdx[0]] :
						alarmW[byteIdx[1:0]]; // R12
				end else if (step == 2'h2) begin
					if (op == OP_CANCEL) begin
						pAddr = DEV_ALARM_D;
						pLen  = ALARM_D_BYTES;
						pByte = ALARM_D_CANCEL; // R12
					end else begin
						pByte = (op == OP_ALARM_W) ?
							ctrl1Word(1'b1, dEn, periodSel) :
							ctrl1Word(wEn, 1'b1, periodSel); // R11
					end
				end
			end
			default: ;
		endcase
	end

	assign cmdWr    = regWr && (regAddr == REG_CMD);
	assign frameEnd = (state == ST_DATA) && shDone &&
		(byteIdx == pLen - 3'h1);
	assign opEnd    = (state == ST_GAP) && !pValid &&
		(gapCnt == 8'(FRAME_GAP_CYCLES - 1));

	// Chip enable stays high from the address byte to the last data byte.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			op        <= OP_NONE;
			step      <= 2'h0;
			byteIdx   <= 3'h0;
			gapCnt    <= 8'h00;
			servicing <= 1'b0;
			ceOut     <= 1'b0;
			shStart   <= 1'b0;
			shByte    <= 8'h00;
			shWrite   <= 1'b0;
		end else begin
			shStart <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					gapCnt <= 8'h00;
					step   <= 2'h0;
					if (cmdWr && powerReady && cmdOp != OP_NONE) begin
						op        <= cmdOp; // R01
						servicing <= 1'b0;
						state     <= ST_GAP;
					end else if (!cmdWr && powerReady && !irqSync &&
						cfg[CFG_SERVICE]) begin
						op        <= OP_READ_TIME; // R06
						servicing <= 1'b1;
						state     <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (gapCnt != 8'(FRAME_GAP_CYCLES - 1)) begin
						gapCnt <= gapCnt + 8'h01;
					end else if (pValid) begin
						gapCnt  <= 8'h00;
						byteIdx <= 3'h0;
						ceOut   <= 1'b1; // R04 R05
						shStart <= 1'b1;
						shByte  <= {pAddr, pWrite ? MODE_WRITE : MODE_READ};
						shWrite <= 1'b1;
						state   <= ST_ADDR;
					end else begin
						op        <= OP_NONE;
						servicing <= 1'b0;
						state     <= ST_IDLE;
					end
				end
				ST_ADDR: begin
					if (shDone) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					shStart <= 1'b1;
					shByte  <= pByte;
					shWrite <= pWrite;
					state   <= ST_DATA;
				end
				ST_DATA: begin
					if (frameEnd) begin
						ceOut <= 1'b0;
						step  <= step + 2'h1;
						state <= ST_GAP;
					end else if (shDone) begin
						byteIdx <= byteIdx + 3'h1;
						state   <= ST_LOAD;
					end
				end
			endcase
		end
	end

	// Device state mirrored from the frames as they finish.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			coldStart <= 1'b0;
			needFull  <= 1'b1;
			wEn       <= 1'b0;
			dEn       <= 1'b0;
		end else if (frameEnd) begin
			if (op == OP_INIT && step == 2'h0) begin
				coldStart <= shRx[CT1_COLD_START_BIT]; // R02
			end
			if (op == OP_SET_TIME && step == 2'h0) begin
				needFull <= 1'b1; // R09
			end
			if (op == OP_READ_TIME && step == 2'h0 && pLen == TIME_BYTES) begin
				needFull <= 1'b0; // R09
			end
			if (pWrite && pAddr == DEV_CTRL1) begin
				wEn <= pByte[CT1_WEEKDAY_EN_BIT]; // R14
				dEn <= pByte[CT1_DAILY_EN_BIT]; // R14
			end
		end
	end

	// Software settings; a time read overwrites the buffer byte by byte.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cfg       <= CFG_RESET;
			periodSel <= 3'h0;
			oscAdj    <= 8'h00;
			mask      <= '0;
			for (int i = 0; i < 7; i++) begin
				timeBuf[i] <= 8'h00;
			end
			for (int i = 0; i < 3; i++) begin
				alarmW[i] <= 8'h00;
			end
			alarmD[0] <= 8'h00;
			alarmD[1] <= 8'h00;
		end else begin
			if (regWr) begin
				if (regAddr == REG_CFG) cfg <= regWdata[2:0];
				if (regAddr == REG_PERIOD) periodSel <= regWdata[2:0];
				if (regAddr == REG_OSC) oscAdj <= regWdata;
				if (regAddr == REG_MASK) mask <= regWdata[EV_W-1:0];
				if (regAddr >= REG_TIME && regAddr < REG_ALARM_W) begin
					timeBuf[3'(regAddr - REG_TIME)] <= regWdata;
				end
				if (regAddr >= REG_ALARM_W && regAddr < REG_ALARM_D) begin
					alarmW[2'(regAddr - REG_ALARM_W)] <= regWdata;
				end
				if (regAddr >= REG_ALARM_D && regAddr < REG_STATUS) begin
					alarmD[1'(regAddr - REG_ALARM_D)] <= regWdata;
				end
			end
			if (state == ST_DATA && shDone && !pWrite &&
				op == OP_READ_TIME) begin
				timeBuf[byteIdx] <= shRx; // R05
			end
		end
	end

	always_comb begin
		evSet = '0;
		evSet[EV_DONE]     = opEnd;
		evSet[EV_COLD]     = frameEnd && op == OP_INIT && step == 2'h0 &&
			shRx[CT1_COLD_START_BIT];
		evSet[EV_SERVICED] = opEnd && servicing;
		evSet[EV_REFUSED]  = cmdWr &&
			(state != ST_IDLE || !powerReady || cmdOp == OP_NONE);
	end

	// Reading the status register clears it; a new event in that cycle wins.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			status <= '0;
		end else if (regRd && regAddr == REG_STATUS) begin
			status <= evSet;
		end else begin
			status <= status | evSet;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		unique case (regAddr)
			REG_CMD:    next_rdata = {5'h00, op};
			REG_CFG:    next_rdata = {5'h00, cfg};
			REG_PERIOD: next_rdata = {5'h00, periodSel};
			REG_OSC:    next_rdata = oscAdj;
			REG_STATUS: next_rdata = {4'h0, status};
			REG_MASK:   next_rdata = {4'h0, mask};
			REG_INFO:   next_rdata = {2'h0, state != ST_IDLE, powerReady,
				coldStart, needFull, wEn, dEn};
			default: begin
				if (regAddr >= REG_TIME && regAddr < REG_ALARM_W) begin
					next_rdata = timeBuf[3'(regAddr - REG_TIME)];
				end else if (regAddr >= REG_ALARM_W &&
					regAddr < REG_ALARM_D) begin
					next_rdata = alarmW[2'(regAddr - REG_ALARM_W)];
				end else if (regAddr >= REG_ALARM_D &&
					regAddr < REG_STATUS) begin
					next_rdata = alarmD[1'(regAddr - REG_ALARM_D)];
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRd ? next_rdata : 8'h00;
		end
	end
endmodule // rtchs_host_seq

// file: verilog/rtchs_pkg.sv
// Constants and types shared by the clock host sequencer and its shifter.
package rtchs_pkg;
	// Timing, in the units printed, and the cycle counts derived at 5 ns.
	localparam int CLK_PERIOD_NS       = 5;
	localparam int SCLK_MIN_PERIOD_NS  = 1000;
	localparam int SCLK_HALF_CYCLES    =
		(SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FRAME_GAP_NS        = 1000;
	localparam int FRAME_GAP_CYCLES    =
		(FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWER_INIT_MS       = 1000;
	localparam int POWER_INIT_CYCLES_DEF =
		POWER_INIT_MS * 1000000 / CLK_PERIOD_NS;

	// Device register addresses, frame mode nibbles and frame byte counts.
	localparam logic [3:0] DEV_SEC      = 4'h0;
	localparam logic [3:0] DEV_OSC_ADJ  = 4'h7;
	localparam logic [3:0] DEV_ALARM_W  = 4'h8;
	localparam logic [3:0] DEV_ALARM_D  = 4'hB;
	localparam logic [3:0] DEV_CTRL1    = 4'hE;
	localparam logic [3:0] DEV_CTRL2    = 4'hF;
	localparam logic [3:0] MODE_WRITE   = 4'h0;
	localparam logic [3:0] MODE_READ    = 4'hC;
	localparam logic [2:0] TIME_BYTES   = 3'h7;
	localparam logic [2:0] REDUCED_BYTES = 3'h5;
	localparam logic [2:0] ALARM_W_BYTES = 3'h3;
	localparam logic [2:0] ALARM_D_BYTES = 3'h2;

	// Device control register fields and alarm cancel patterns.
	localparam int CT1_WEEKDAY_EN_BIT  = 7;
	localparam int CT1_DAILY_EN_BIT    = 6;
	localparam int CT1_COLD_START_BIT  = 4;
	localparam logic [2:0] CT1_LEVEL_MODE = 3'h4;
	localparam int CT2_DROP_BIT        = 6;
	localparam int CT2_PERIODIC_BIT    = 2;
	localparam logic [7:0] CT2_KEEP    = 8'hFF;
	localparam logic [7:0] ALARM_W_CANCEL = 8'h75;
	localparam logic [7:0] ALARM_D_CANCEL = 8'h76;

	// Host register map.
	localparam logic [4:0] REG_CMD     = 5'h00;
	localparam logic [4:0] REG_CFG     = 5'h01;
	localparam logic [4:0] REG_PERIOD  = 5'h02;
	localparam logic [4:0] REG_OSC     = 5'h03;
	localparam logic [4:0] REG_TIME    = 5'h04;
	localparam logic [4:0] REG_ALARM_W = 5'h0B;
	localparam logic [4:0] REG_ALARM_D = 5'h0E;
	localparam logic [4:0] REG_STATUS  = 5'h10;
	localparam logic [4:0] REG_MASK    = 5'h11;
	localparam logic [4:0] REG_INFO    = 5'h12;

	localparam logic [7:0] CMD_INIT     = 8'h01;
	localparam logic [7:0] CMD_SET_TIME = 8'h02;
	localparam logic [7:0] CMD_READ_TIME = 8'h03;
	localparam logic [7:0] CMD_ALARM_W  = 8'h04;
	localparam logic [7:0] CMD_ALARM_D  = 8'h05;
	localparam logic [7:0] CMD_CANCEL   = 8'h06;

	localparam int CFG_MONITOR = 0;
	localparam int CFG_REDUCED = 1;
	localparam int CFG_SERVICE = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	localparam int EV_DONE     = 0;
	localparam int EV_COLD     = 1;
	localparam int EV_SERVICED = 2;
	localparam int EV_REFUSED  = 3;
	localparam int EV_W        = 4;

	typedef enum logic [2:0] {
		OP_NONE, OP_INIT, OP_SET_TIME, OP_READ_TIME,
		OP_ALARM_W, OP_ALARM_D, OP_CANCEL
	} rtchs_op_e;

	typedef enum logic [2:0] {
		ST_IDLE, ST_GAP, ST_ADDR, ST_LOAD, ST_DATA
	} rtchs_state_e;
endpackage

// file: verilog/rtchs_serial_shifter.sv
// One byte over the three-wire link, with the serial clock divided down.
`timescale 1ns/1ps
module rtchs_serial_shifter (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Byte request and result.
	input  wire logic       start,
	input  wire logic [7:0] txByte,
	input  wire logic       isWrite,
	output logic            done,
	output logic [7:0]      rxByte,
	// Serial pins.
	output logic            sclkOut,
	output logic            sdOut,
	output logic            sdOe,
	input  wire logic       sdIn
);
	import rtchs_pkg::*;

	logic       sdMeta;
	logic       sdSync;
	logic       busy;
	logic       phase;
	logic [2:0] bitCnt;
	logic [7:0] halfCnt;
	logic [7:0] shReg;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sdMeta <= 1'b0;
			sdSync <= 1'b0;
		end else begin
			sdMeta <= sdIn;
			sdSync <= sdMeta;
		end
	end

	// Data changes while the clock is low; input is sampled at the end of
	// the high half, just before the falling edge.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			busy    <= 1'b0;
			phase   <= 1'b0;
			bitCnt  <= 3'h0;
			halfCnt <= 8'h00;
			shReg   <= 8'h00;
			done    <= 1'b0;
			rxByte  <= 8'h00;
			sclkOut <= 1'b0;
			sdOut   <= 1'b0;
			sdOe    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy    <= 1'b1;
					phase   <= 1'b0;
					bitCnt  <= 3'h7;
					halfCnt <= 8'h00;
					shReg   <= txByte;
					sdOut   <= txByte[7] & isWrite;
					sdOe    <= isWrite;
				end
			end else if (halfCnt != 8'(SCLK_HALF_CYCLES - 1)) begin
				halfCnt <= halfCnt + 8'h01;
			end else begin
				halfCnt <= 8'h00;
				if (!phase) begin
					sclkOut <= 1'b1;
					phase   <= 1'b1;
				end else begin
					sclkOut <= 1'b0;
					phase   <= 1'b0;
					shReg   <= {shReg[6:0], sdSync};
					if (bitCnt == 3'h0) begin
						busy   <= 1'b0;
						done   <= 1'b1;
						rxByte <= {shReg[6:0], sdSync};
						sdOe   <= 1'b0;
						sdOut  <= 1'b0;
					end else begin
						bitCnt <= bitCnt - 3'h1;
						if (sdOe) begin
							sdOut <= shReg[6];
						end
					end
				end
			end
		end
	end
endmodule // rtchs_serial_shifter

// file: tb/rtchs_host_seq_props.sv
// Checker for the clock host sequencer's link and register port.
`timescale 1ns/1ps
module rtchs_host_seq_props #(
	parameter int POWER_INIT_CYCLES = 20
) (
	// Clock and reset.
	input wire logic       ref_clk,
	input wire logic       rstn,
	// Register port.
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       irq,
	// Link and device pins.
	input wire logic       ceOut,
	input wire logic       sclkOut,
	input wire logic       serialDataLineOut,
	input wire logic       serialDataLineOe,
	input wire logic       supplyDetectOut,
	input wire logic       irqOutN
);
	logic [7:0]  hiCnt;
	logic [7:0]  loCnt;
	logic [7:0]  bitCnt;
	logic [31:0] upCnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge ref_clk) begin
		hiCnt <= (rstn && sclkOut) ? hiCnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge ref_clk) begin
		loCnt <= (rstn && ceOut && !sclkOut) ? loCnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge ref_clk) begin
		upCnt <= (rstn && supplyDetectOut) ? upCnt + 32'h1 : 32'h0;
	end
	// Counts serial clock rises within the current frame.
	always_ff @(posedge ref_clk) begin
		if (!rstn || !ceOut)
			bitCnt <= 8'h00;
		else if (sclkOut && hiCnt == 8'h00)
			bitCnt <= bitCnt + 8'h01;
	end
	property p_reset_quiet;
		$rose(rstn) |-> !ceOut && !sclkOut && !serialDataLineOe && !irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("link or irq active at reset release");
	property p_power_wait;
		$rose(ceOut) |-> upCnt >= POWER_INIT_CYCLES;
	endproperty
	a_power_wait: assert property (p_power_wait)
		else $error("frame started before supply settled");
	property p_whole_bytes;
		$fell(ceOut) |-> bitCnt[2:0] == 3'h0 && bitCnt >= 8'h10;
	endproperty
	a_whole_bytes: assert property (p_whole_bytes)
		else $error("frame ended inside a byte");
	property p_sclk_in_frame;
		sclkOut |-> ceOut;
	endproperty
	a_sclk_in_frame: assert property (p_sclk_in_frame)
		else $error("serial clock outside frame");
	property p_high_half;
		$fell(sclkOut) |-> hiCnt == 8'h64;
	endproperty
	a_high_half: assert property (p_high_half)
		else $error("serial clock high half wrong");
	property p_low_half;
		$rose(sclkOut) |-> loCnt == 8'h64 || loCnt == 8'h65 ||
			loCnt == 8'h67;
	endproperty
	a_low_half: assert property (p_low_half)
		else $error("serial clock low half wrong");
	property p_data_stable;
		sclkOut && $past(sclkOut) && serialDataLineOe
			|-> $stable(serialDataLineOut);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data changed while serial clock high");
	property p_oe_in_frame;
		$rose(serialDataLineOe) |-> ceOut;
	endproperty
	a_oe_in_frame: assert property (p_oe_in_frame)
		else $error("line driven outside frame");
	property p_rdata_idle;
		!regRd |=> regRdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data without read strobe");
	c_frame: cover property ($rose(ceOut));
	c_irq: cover property ($rose(irq));
	c_dev_irq: cover property ($fell(irqOutN));
endmodule // rtchs_host_seq_props

bind rtchs_host_seq rtchs_host_seq_props #(
	.POWER_INIT_CYCLES(POWER_INIT_CYCLES)
) u_props (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.regRd(regRd),
	.regRdata(regRdata),
	.irq(irq),
	.ceOut(ceOut),
	.sclkOut(sclkOut),
	.serialDataLineOut(serialDataLineOut),
	.serialDataLineOe(serialDataLineOe),
	.supplyDetectOut(supplyDetectOut),
	.irqOutN(irqOutN)
);

// file: tb/rtchs_dev_model.sv
// Behavioural clock chip on the far side of the three-wire link.
`timescale 1ns/1ps
module rtchs_dev_model (
	// Link pins.
	input  wire logic ce,
	input  wire logic sclk,
	input  wire logic sdIn,
	output logic      sdOut,
	output logic      sdOe,
	// Supply and status pins.
	input  wire logic powerOn,
	input  wire logic coldStart,
	output logic      supplyDetectOut,
	output logic      irqOutN
);
	logic [7:0] regs [16];
	logic [7:0] sh;
	logic [7:0] rdSh;
	logic [7:0] timeWrLen;
	logic [7:0] timeRdLen;
	logic [7:0] nBytes;
	logic [3:0] addr;
	logic [3:0] first;
	logic       isRd;
	logic       alarmBad = 1'b0;
	int         bits;
	initial begin
		sdOut = 1'b0;
		sdOe = 1'b0;
		foreach (regs[i]) regs[i] = 8'h00;
	end
	assign supplyDetectOut = powerOn;
	assign irqOutN = !((regs[15][2] && regs[14][2])
		|| (regs[15][1] && regs[14][7]) || (regs[15][0] && regs[14][6]));
	always @(posedge powerOn) regs[14][4] = coldStart;
	always @(posedge ce) begin
		bits = 0;
		nBytes = 8'h00;
		isRd = 1'b0;
	end
	// A released line shows the inverse of its last bit.
	always @(negedge ce) begin
		sdOe = 1'b0;
		sdOut = ~sdOut;
		if (first == 4'h0 && isRd) timeRdLen = nBytes;
		if (first == 4'h0 && !isRd) timeWrLen = nBytes;
	end
	always @(posedge sclk) sh = {sh[6:0], sdIn};
	always @(negedge sclk) if (ce) begin
		bits++;
		if (bits == 8) begin
			addr = sh[7:4];
			first = sh[7:4];
			isRd = sh[3:0] == 4'hC;
		end else if (bits % 8 == 0) begin
			if (!isRd && addr inside {[8:10]} && regs[14][7]) alarmBad = 1'b1;
			if (!isRd && addr inside {[11:12]} && regs[14][6]) alarmBad = 1'b1;
			if (!isRd) regs[addr] = (addr == 4'hF) ? regs[addr] & sh : sh;
			addr++;
			nBytes++;
		end
		if (isRd && bits % 8 == 0) rdSh = regs[addr];
		if (isRd) begin
			sdOe = 1'b1;
			sdOut = rdSh[7];
			rdSh = {rdSh[6:0], 1'b0};
		end
	end
endmodule // rtchs_dev_model

// file: tb/rtchs_host_seq_tb.sv
// Self-checking bench for the clock host sequencer.
`timescale 1ns/1ps
module rtchs_host_seq_tb;
	import rtchs_pkg::*;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} rtchs_row_s;
	localparam int PI = 20;
	// Unknown command code; the sequencer must refuse it.
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam rtchs_row_s ROWS [13] = '{
		'{REG_OSC, 8'h5A, 8'h5A}, '{5'h04, 8'h45, 8'h45},
		'{5'h05, 8'h59, 8'h59}, '{5'h06, 8'h23, 8'h23},
		'{5'h07, 8'h06, 8'h06}, '{5'h08, 8'h31, 8'h31},
		'{5'h09, 8'h12, 8'h12}, '{5'h0A, 8'h99, 8'h99},
		'{5'h0B, 8'h30, 8'h30}, '{5'h0C, 8'h12, 8'h12},
		'{5'h0D, 8'h41, 8'h41}, '{REG_CFG, 8'h01, 8'h01},
		'{5'h1F, 8'hAA, 8'h00}};
	logic       ref_clk = 1'b0;
	logic       rstn = 1'b0;
	logic [4:0] regAddr = 5'h00;
	logic [7:0] regWdata = 8'h00;
	logic       regWr = 1'b0;
	logic       regRd = 1'b0;
	logic       powerOn = 1'b0;
	logic       coldStart = 1'b1;
	logic [7:0] regRdata;
	logic       irq, ceOut, sclkOut, hostOut, hostOe, devOut, devOe;
	logic       supDet, irqN;
	wire        lineIn = hostOe ? hostOut : devOut;
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cycles = 0;
	rtchs_host_seq #(.POWER_INIT_CYCLES(PI)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq), .ceOut(ceOut), .sclkOut(sclkOut),
		.serialDataLineOut(hostOut), .serialDataLineOe(hostOe),
		.serialDataLineIn(lineIn), .supplyDetectOut(supDet),
		.irqOutN(irqN));
	rtchs_dev_model dev (
		.ce(ceOut), .sclk(sclkOut), .sdIn(lineIn), .sdOut(devOut),
		.sdOe(devOe), .powerOn(powerOn), .coldStart(coldStart),
		.supplyDetectOut(supDet), .irqOutN(irqN));
	always #2.5 ref_clk = ~ref_clk;
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 105000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] m, e);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk(regRdata & m, e);
	endtask
	// Polls the busy bit, which stays set through the closing gap, then waits 210 cycles.
	task automatic cmd(input logic [7:0] c);
		wr(REG_CMD, c);
		for (int i = 0; i < 40000; i++) begin
			@(posedge ref_clk);
			regAddr <= REG_INFO;
			regRd <= 1'b1;
			@(posedge ref_clk);
			regRd <= 1'b0;
			#1 if (regRdata[5] === 1'b0) break;
		end
		repeat (210) @(posedge ref_clk);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		wr(REG_MASK, 8'h00);
		wr(REG_CMD, CMD_INIT);
		repeat (3) @(posedge ref_clk);
		#1 chk({7'h0, irq}, 8'h00);
		wr(REG_MASK, 8'h08);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h0, irq}, 8'h01);
		rchk(REG_STATUS, 8'hFF, 8'h08);
		rchk(REG_INFO, 8'h10, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h0, irq}, 8'h00);
		powerOn <= 1'b1;
		repeat (PI + 8) @(posedge ref_clk);
		rchk(REG_INFO, 8'h10, 8'h10);
		foreach (ROWS[i]) wr(ROWS[i].a, ROWS[i].d);
		foreach (ROWS[i]) rchk(ROWS[i].a, 8'hFF, ROWS[i].e);
		wr(REG_PERIOD, 8'h01);
		cmd(CMD_INIT);
		rchk(REG_STATUS, 8'h03, 8'h03);
		chk(dev.regs[7], 8'h5A);
		chk({5'h0, dev.regs[14][2:0]}, 8'h05);
		dev.regs[15] = 8'h40;
		cmd(CMD_SET_TIME);
		for (int k = 0; k < 7; k++) chk(dev.regs[k], ROWS[k + 1].d);
		chk(dev.timeWrLen, 8'h07);
		chk(dev.regs[15] & 8'h40, 8'h00);
		for (int k = 0; k < 7; k++) dev.regs[k] = 8'h10 + 8'(k);
		cmd(CMD_READ_TIME);
		for (int k = 0; k < 7; k++) rchk(REG_TIME + 5'(k), 8'hFF, 8'h10 + 8'(k));
		chk(dev.timeRdLen, 8'h07);
		wr(REG_CFG, 8'h03);
		cmd(CMD_READ_TIME);
		chk(dev.timeRdLen, 8'h05);
		wr(REG_CFG, 8'h07);
		dev.regs[15][2] = 1'b1;
		#1 chk({7'h0, irqN}, 8'h00);
		for (int i = 0; i < 30000 && irqN !== 1'b1; i++) @(posedge ref_clk);
		chk({7'h0, irqN}, 8'h01);
		cmd(CMD_NONE);
		rchk(REG_STATUS, 8'h04, 8'h04);
		dev.regs[14][7] = 1'b1;
		cmd(CMD_ALARM_W);
		chk({7'h0, dev.alarmBad}, 8'h00);
		chk({7'h0, dev.regs[14][7]}, 8'h01);
		for (int k = 0; k < 3; k++) chk(dev.regs[8 + k], ROWS[k + 8].d);
		wr(REG_CMD, CMD_CANCEL);
		cmd(CMD_INIT);
		rchk(REG_STATUS, 8'h08, 8'h08);
		for (int k = 0; k < 5; k++) chk(dev.regs[8 + k], k < 3 ? 8'h75 : 8'h76);
		chk({6'h0, dev.regs[14][7:6]}, 8'h00);
		dev.regs[15][1] = 1'b1;
		#1 chk({7'h0, irqN}, 8'h01);
		give_verdict();
	end
endmodule // rtchs_host_seq_tb
